// ---- rtl/sdc_check.sv ----
// descriptor decode and access check with an apb register port
// Notes on behaviour
// - user flag 1 and type bit 11 clear means data segment
// - type bits 10:8 give expand-down, writable and accessed
// - expand-down accepts offsets from limit plus one to upper bound
// - expand-down upper bound is 32-bit max if size flag set, else 16-bit
// - expand-up accepts offsets from zero through the limit
// - writing a read-only data segment gives a protection fault
// - loading data or stack register sets accessed; never cleared here
// - stack load needs a valid writable data descriptor
// - stack uses wide pointer if size flag set, narrow otherwise
// - execution from a data segment is refused
// - user flag 0 means system descriptor, kind from 4-bit type
// - decode task-state and local-table system codes
// - decode call, task, interrupt and trap gate codes
// - codes 0000, 1000, 1010, 1101 are reserved and illegal
// - compatibility mode uses the same system decode
// - granularity set scales limit by 4096 bytes
// - descriptor not present raises the absent-segment fault
// - every byte of a multi-byte access must lie in range
`include "sdc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sdc_check (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic             wide_stack_pointer,
	output logic             general_protection_fault,
	output logic             segment_absent_fault
);

	logic [31:0]            desc_lo;
	logic [31:0]            desc_hi;
	logic [31:0]            offset;
	sdc_pkg::sdc_ctrl_type  ctrl;
	sdc_pkg::sdc_result_type result;
	logic [`SDC_IRQ_W-1:0]  int_stat;
	logic [`SDC_IRQ_W-1:0]  int_mask;
	logic                   start;

	logic                   apb_done;
	logic                   wr_done;
	logic [3:0]             dtype;
	logic                   is_user;
	logic                   is_data;
	logic                   is_sys;
	logic                   present;
	logic                   dsize;
	logic [19:0]            lim_raw;
	logic [32:0]            limit;
	logic [32:0]            upper;
	logic [32:0]            first_b;
	logic [32:0]            last_b;
	logic                   in_range;
	sdc_pkg::sdc_sys_kind_type kind;
	logic                   illegal;
	logic                   gp;
	logic                   np;
	logic                   load_op;
	logic                   set_acc;
	sdc_pkg::sdc_result_type next_result;
	logic [`SDC_IRQ_W-1:0]  events;
	logic [31:0]            rd_mux;
	logic                   rd_err;

	// apb handshake: one wait state, transfer ends when pready is seen
	assign apb_done = psel & penable & pready;
	assign wr_done  = apb_done & pwrite & ~pslverr;

	// field extraction
	assign dtype   = desc_hi[`SDC_BIT_ACCESSED +: 4];
	assign is_user = desc_hi[`SDC_BIT_USER];
	assign is_data = is_user & ~desc_hi[`SDC_BIT_CODE];
	assign is_sys  = ~is_user;
	assign present = desc_hi[`SDC_BIT_PRESENT];
	assign dsize   = desc_hi[`SDC_BIT_DSIZE];
	assign lim_raw = {desc_hi[19:16], desc_lo[15:0]};

	// effective limit, scaled to 4 KiB blocks when granular
	assign limit = desc_hi[`SDC_BIT_GRAN] ? {1'b0, lim_raw, `SDC_GRAN_FILL}
		: {13'h0000, lim_raw};
	assign upper = dsize ? `SDC_UPPER_WIDE : `SDC_UPPER_NARROW;

	// first and last byte of the access, carried to 33 bits
	assign first_b = {1'b0, offset};
	assign last_b  = first_b + {31'h0000_0000, ctrl.size_m1};

	// bound check by expansion direction
	always_comb begin
		if (desc_hi[`SDC_BIT_EXPDOWN]) begin
			in_range = (first_b > limit) && (last_b <= upper);
		end else begin
			in_range = last_b <= limit;
		end
	end

	// system type decode, identical in legacy and compatibility mode
	always_comb begin
		illegal = 1'b0;
		case (dtype)
			4'h1: kind = sdc_pkg::SDC_SYS_TSS16_AVL;
			4'h2: kind = sdc_pkg::SDC_SYS_LOCAL_TBL;
			4'h3: kind = sdc_pkg::SDC_SYS_TSS16_BUSY;
			4'h4: kind = sdc_pkg::SDC_SYS_CALL16;
			4'h5: kind = sdc_pkg::SDC_SYS_TASK_GATE;
			4'h6: kind = sdc_pkg::SDC_SYS_INT16;
			4'h7: kind = sdc_pkg::SDC_SYS_TRAP16;
			4'h9: kind = sdc_pkg::SDC_SYS_TSS32_AVL;
			4'hb: kind = sdc_pkg::SDC_SYS_TSS32_BUSY;
			4'hc: kind = sdc_pkg::SDC_SYS_CALL32;
			4'he: kind = sdc_pkg::SDC_SYS_INT32;
			4'hf: kind = sdc_pkg::SDC_SYS_TRAP32;
			default: begin
				kind    = sdc_pkg::SDC_SYS_RESERVED;
				illegal = 1'b1;
			end
		endcase
		if (!is_sys) begin
			kind    = sdc_pkg::SDC_SYS_NONE;
			illegal = 1'b0;
		end
	end

	// fault evaluation for the requested operation
	always_comb begin
		gp      = 1'b0;
		np      = 1'b0;
		load_op = 1'b0;
		case (ctrl.op)
			sdc_pkg::SDC_OP_ACCESS: begin
				if (!is_data || ctrl.exec) begin
					gp = 1'b1;
				end else if (!present) begin
					np = 1'b1;
				end else if (ctrl.write && !desc_hi[`SDC_BIT_WRITABLE]) begin
					gp = 1'b1;
				end else if (!in_range) begin
					gp = 1'b1;
				end
			end
			sdc_pkg::SDC_OP_DATA_LOAD: begin
				load_op = 1'b1;
				if (!is_data) begin
					gp = 1'b1;
				end else if (!present) begin
					np = 1'b1;
				end
			end
			sdc_pkg::SDC_OP_STACK_LOAD: begin
				load_op = 1'b1;
				if (!is_data || !desc_hi[`SDC_BIT_WRITABLE]) begin
					gp = 1'b1;
				end else if (!present) begin
					np = 1'b1;
				end
			end
			default: begin
				load_op = 1'b0;
			end
		endcase
	end

	// accessed flag is set only by a successful load
	assign set_acc = start & load_op & ~gp & ~np;

	// result word assembled from the decode
	always_comb begin
		next_result             = result;
		next_result.is_data     = is_data;
		next_result.is_sys      = is_sys;
		next_result.kind        = kind;
		next_result.illegal     = illegal;
		next_result.gp          = gp;
		next_result.np          = np;
		next_result.stack_wide  = (ctrl.op == sdc_pkg::SDC_OP_STACK_LOAD && !gp && !np)
			? dsize : result.stack_wide;
		next_result.expand_down = is_data & desc_hi[`SDC_BIT_EXPDOWN];
		next_result.writable    = is_data & desc_hi[`SDC_BIT_WRITABLE];
		next_result.accessed    = is_data & (desc_hi[`SDC_BIT_ACCESSED] | set_acc);
	end

	// events reported by a finished check
	assign events = {`SDC_IRQ_W{start}} & {illegal, np, gp, 1'b1};

	// software-written lower descriptor word and offset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			desc_lo <= `SDC_RST_WORD;
			offset  <= `SDC_RST_WORD;
		end else if (ce && wr_done) begin
			if (paddr == `SDC_OFS_DESC_LO) begin
				desc_lo <= pwdata;
			end else if (paddr == `SDC_OFS_OFFSET) begin
				offset <= pwdata;
			end
		end
	end

	// upper word: hardware setting the accessed flag wins over a write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			desc_hi <= `SDC_RST_WORD;
		end else if (ce) begin
			if (wr_done && paddr == `SDC_OFS_DESC_HI) begin
				desc_hi <= pwdata | {23'h000000, set_acc, 8'h00};
			end else if (set_acc) begin
				desc_hi[`SDC_BIT_ACCESSED] <= 1'b1;
			end
		end
	end

	// control write launches a check in the next cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl  <= '{compat: 1'b0, size_m1: 2'b00, exec: 1'b0, write: 1'b0,
				op: sdc_pkg::SDC_OP_NONE};
			start <= 1'b0;
		end else if (ce) begin
			start <= wr_done && (paddr == `SDC_OFS_CTRL);
			if (wr_done && paddr == `SDC_OFS_CTRL) begin
				ctrl <= sdc_pkg::sdc_ctrl_type'(pwdata[6:0]);
			end
		end
	end

	// result and fault outputs updated by each check
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			result                   <= '0;
			wide_stack_pointer       <= 1'b0;
			general_protection_fault <= 1'b0;
			segment_absent_fault     <= 1'b0;
		end else if (ce && start) begin
			result                   <= next_result;
			wide_stack_pointer       <= next_result.stack_wide;
			general_protection_fault <= gp;
			segment_absent_fault     <= np;
		end
	end

	// sticky status, cleared by writing one; a new event wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			int_stat <= '0;
			int_mask <= `SDC_RST_MASK;
			irq      <= 1'b0;
		end else if (ce) begin
			if (wr_done && paddr == `SDC_OFS_INT_STAT) begin
				int_stat <= (int_stat & ~pwdata[`SDC_IRQ_W-1:0]) | events;
			end else begin
				int_stat <= int_stat | events;
			end
			if (wr_done && paddr == `SDC_OFS_INT_MASK) begin
				int_mask <= pwdata[`SDC_IRQ_W-1:0];
			end
			irq <= |(int_stat & int_mask);
		end
	end

	// read mux and unmapped-address detection
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		if (paddr == `SDC_OFS_DESC_LO) begin
			rd_mux = desc_lo;
		end else if (paddr == `SDC_OFS_DESC_HI) begin
			rd_mux = desc_hi;
		end else if (paddr == `SDC_OFS_OFFSET) begin
			rd_mux = offset;
		end else if (paddr == `SDC_OFS_CTRL) begin
			rd_mux = {25'h0000000, ctrl};
		end else if (paddr == `SDC_OFS_RESULT) begin
			rd_mux = {19'h00000, result};
		end else if (paddr == `SDC_OFS_INT_STAT) begin
			rd_mux = {28'h0000000, int_stat};
		end else if (paddr == `SDC_OFS_INT_MASK) begin
			rd_mux = {28'h0000000, int_mask};
		end else begin
			rd_err = 1'b1;
		end
	end

	// apb answer one cycle into the access phase
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & rd_err;
			if (psel && penable && !pready && !pwrite) begin
				prdata <= rd_mux;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	data_class_a: assert property (
		start && ce |=> result.is_data ==
		($past(desc_hi[`SDC_BIT_USER]) && !$past(desc_hi[`SDC_BIT_CODE])))
		else $error("data class mismatch");
	expdown_bound_a: assert property (
		start && ce && is_data && present && ctrl.op == sdc_pkg::SDC_OP_ACCESS &&
		!ctrl.exec && !ctrl.write && desc_hi[`SDC_BIT_EXPDOWN] && first_b <= limit
		|=> result.gp)
		else $error("expand-down low offset accepted");
	upper_bound_a: assert property (
		start && ce && is_data && present && ctrl.op == sdc_pkg::SDC_OP_ACCESS &&
		!ctrl.exec && !ctrl.write && desc_hi[`SDC_BIT_EXPDOWN] && !dsize &&
		last_b > 33'h0_0000_ffff |=> result.gp)
		else $error("narrow upper bound not enforced");
	expup_bound_a: assert property (
		start && ce && is_data && present && ctrl.op == sdc_pkg::SDC_OP_ACCESS &&
		!ctrl.exec && !ctrl.write && !desc_hi[`SDC_BIT_EXPDOWN] && last_b <= limit
		|=> !result.gp)
		else $error("in-range expand-up access faulted");
	span_bound_a: assert property (
		start && ce && is_data && present && ctrl.op == sdc_pkg::SDC_OP_ACCESS &&
		!ctrl.exec && !desc_hi[`SDC_BIT_EXPDOWN] && first_b <= limit && last_b > limit
		|=> result.gp)
		else $error("straddling access accepted");
	ro_write_a: assert property (
		start && ce && is_data && present && ctrl.op == sdc_pkg::SDC_OP_ACCESS &&
		ctrl.write && !desc_hi[`SDC_BIT_WRITABLE] |=> general_protection_fault)
		else $error("write to read-only segment allowed");
	acc_sticky_a: assert property (
		ce && desc_hi[`SDC_BIT_ACCESSED] && !(wr_done && paddr == `SDC_OFS_DESC_HI)
		|=> desc_hi[`SDC_BIT_ACCESSED])
		else $error("accessed flag cleared by hardware");
	acc_set_a: assert property (
		start && ce && load_op && !gp && !np |=> desc_hi[`SDC_BIT_ACCESSED])
		else $error("accessed flag not set on load");
	stack_load_a: assert property (
		start && ce && ctrl.op == sdc_pkg::SDC_OP_STACK_LOAD &&
		!desc_hi[`SDC_BIT_WRITABLE] |=> general_protection_fault && !segment_absent_fault)
		else $error("read-only stack load accepted");
	stack_width_a: assert property (
		start && ce && ctrl.op == sdc_pkg::SDC_OP_STACK_LOAD && !gp && !np
		|=> wide_stack_pointer == $past(dsize))
		else $error("stack width not taken from size flag");
	exec_data_a: assert property (
		start && ce && ctrl.op == sdc_pkg::SDC_OP_ACCESS && ctrl.exec
		|=> general_protection_fault)
		else $error("execution from data segment allowed");
	sys_class_a: assert property (
		start && ce |=> result.is_sys == !$past(desc_hi[`SDC_BIT_USER]))
		else $error("system class mismatch");
	gate_code_a: assert property (
		start && ce && is_sys && dtype == 4'h5 |=> result.kind == sdc_pkg::SDC_SYS_TASK_GATE)
		else $error("task gate not decoded");
	illegal_type_a: assert property (
		start && ce && is_sys && (dtype == 4'h0 || dtype == 4'h8 || dtype == 4'ha ||
		dtype == 4'hd) |=> result.illegal && int_stat[`SDC_IRQ_ILLEGAL])
		else $error("reserved system type not flagged");
	absent_a: assert property (
		start && ce && is_data && !present && ctrl.op == sdc_pkg::SDC_OP_DATA_LOAD
		|=> segment_absent_fault)
		else $error("absent segment not faulted");
	apb_answer_a: assert property (
		psel && penable && !pready && ce |=> pready ##1 (!pready || !ce))
		else $error("apb answer timing wrong");

	gp_seen_c: cover property (start && ce && gp);
	stack_wide_c: cover property (start && ce && ctrl.op == sdc_pkg::SDC_OP_STACK_LOAD
		&& !gp && dsize);
	expdown_ok_c: cover property (start && ce && is_data && desc_hi[`SDC_BIT_EXPDOWN]
		&& !gp && !np);
	irq_c: cover property (irq);

endmodule : sdc_check

`default_nettype wire

// ---- rtl/sdc_cfg.svh ----
// offsets, field positions, bounds, interrupt bits and reset values for the descriptor checker
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// register byte offsets
`define SDC_OFS_DESC_LO   12'h000
`define SDC_OFS_DESC_HI   12'h004
`define SDC_OFS_OFFSET    12'h008
`define SDC_OFS_CTRL      12'h00c
`define SDC_OFS_RESULT    12'h010
`define SDC_OFS_INT_STAT  12'h014
`define SDC_OFS_INT_MASK  12'h018

// descriptor upper-word field positions
`define SDC_BIT_ACCESSED  8
`define SDC_BIT_WRITABLE  9
`define SDC_BIT_EXPDOWN   10
`define SDC_BIT_CODE      11
`define SDC_BIT_USER      12
`define SDC_BIT_PRESENT   15
`define SDC_BIT_DSIZE     22
`define SDC_BIT_GRAN      23

// bounds and scaling
`define SDC_UPPER_WIDE    33'h0_ffff_ffff
`define SDC_UPPER_NARROW  33'h0_0000_ffff
`define SDC_GRAN_FILL     12'hfff

// interrupt status bits
`define SDC_IRQ_DONE      0
`define SDC_IRQ_GP        1
`define SDC_IRQ_NP        2
`define SDC_IRQ_ILLEGAL   3
`define SDC_IRQ_W         4

// reset values
`define SDC_RST_WORD      32'h0000_0000
`define SDC_RST_MASK      4'h0

`endif

// ---- rtl/sdc_pkg.sv ----
// types shared by the descriptor checker
package sdc_pkg;

	// operation requested through the control register
	typedef enum logic [1:0] {
		SDC_OP_ACCESS     = 2'b00,
		SDC_OP_DATA_LOAD  = 2'b01,
		SDC_OP_STACK_LOAD = 2'b10,
		SDC_OP_NONE       = 2'b11
	} sdc_op_type;

	// decoded kind of a system descriptor
	typedef enum logic [3:0] {
		SDC_SYS_NONE       = 4'h0,
		SDC_SYS_TSS16_AVL  = 4'h1,
		SDC_SYS_LOCAL_TBL  = 4'h2,
		SDC_SYS_TSS16_BUSY = 4'h3,
		SDC_SYS_CALL16     = 4'h4,
		SDC_SYS_TASK_GATE  = 4'h5,
		SDC_SYS_INT16      = 4'h6,
		SDC_SYS_TRAP16     = 4'h7,
		SDC_SYS_TSS32_AVL  = 4'h8,
		SDC_SYS_TSS32_BUSY = 4'h9,
		SDC_SYS_CALL32     = 4'ha,
		SDC_SYS_INT32      = 4'hb,
		SDC_SYS_TRAP32     = 4'hc,
		SDC_SYS_RESERVED   = 4'hf
	} sdc_sys_kind_type;

	// control register, low bits first from the right
	typedef struct packed {
		logic       compat;
		logic [1:0] size_m1;
		logic       exec;
		logic       write;
		sdc_op_type op;
	} sdc_ctrl_type;

	// result register
	typedef struct packed {
		logic             accessed;
		logic             writable;
		logic             expand_down;
		logic             stack_wide;
		logic             np;
		logic             gp;
		logic             illegal;
		sdc_sys_kind_type kind;
		logic             is_sys;
		logic             is_data;
	} sdc_result_type;

endpackage : sdc_pkg

// ---- test/sdc_check_test.sv ----
// self-checking testbench for the descriptor checker
`include "sdc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sdc_check_test;
	logic        clk     = 1'b0;
	logic        rst_b   = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        wsp;
	logic        gpf;
	logic        npf;
	int          fail_count      = 0;
	int          samples_checked = 0;
	int          cycles          = 0;
	logic [31:0] rd;
	logic        er;
	logic        ce      = 1'b1;
	logic        exp_wsp = 1'b0;

	sdc_check u_dut (
		.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .wide_stack_pointer(wsp),
		.general_protection_fault(gpf), .segment_absent_fault(npf)
	);

	// 125 mhz clock
	initial begin
		forever #4 clk = ~clk;
	end

	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	// one apb transfer; request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [31:0] mk(input logic [1:0] op, input logic wr, ex,
			input logic [1:0] sz, input logic cm);
		sdc_pkg::sdc_ctrl_type c;
		c.op      = sdc_pkg::sdc_op_type'(op);
		c.write   = wr;
		c.exec    = ex;
		c.size_m1 = sz;
		c.compat  = cm;
		return {25'h0, c};
	endfunction : mk

	function automatic logic [31:0] hw(input logic g, d, input logic [3:0] lh,
			input logic p, s, input logic [3:0] t);
		return {8'h00, g, d, 2'b00, lh, p, 2'b00, s, t, 8'h00};
	endfunction : hw

	// expected result word and whether a load succeeds
	function automatic logic [31:0] exp_res(input logic [31:0] hi, lo, off, ctl,
			output logic okl);
		logic        dat, sys, gp, np, ill, inr;
		logic [3:0]  k;
		logic [31:0] lim;
		logic [32:0] last, up;
		dat = hi[12] & ~hi[11];
		sys = ~hi[12];
		case (hi[11:8])
			4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: k = hi[11:8];
			4'h9: k = 4'h8;
			4'hb: k = 4'h9;
			4'hc: k = 4'ha;
			4'he: k = 4'hb;
			4'hf: k = 4'hc;
			default: k = 4'hf;
		endcase
		if (!sys) k = 4'h0;
		ill  = sys & (k == 4'hf);
		lim  = hi[23] ? {hi[19:16], lo[15:0], 12'hfff} : {12'h000, hi[19:16], lo[15:0]};
		last = {1'b0, off} + {31'h0, ctl[5:4]};
		up   = hi[22] ? 33'h0_ffff_ffff : 33'h0_0000_ffff;
		inr  = hi[10] ? (off > lim && last <= up) : (last <= {1'b0, lim});
		gp   = 1'b0;
		np   = 1'b0;
		case (ctl[1:0])
			2'b00: if (!dat || ctl[3]) gp = 1'b1;
				else if (!hi[15]) np = 1'b1;
				else if (ctl[2] && !hi[9]) gp = 1'b1;
				else if (!inr) gp = 1'b1;
			2'b01: if (!dat) gp = 1'b1;
				else if (!hi[15]) np = 1'b1;
			2'b10: if (!dat || !hi[9]) gp = 1'b1;
				else if (!hi[15]) np = 1'b1;
			default: ;
		endcase
		okl = (ctl[1:0] == 2'b01 || ctl[1:0] == 2'b10) && !gp && !np;
		return {19'h0, dat & (hi[8] | okl), hi[9], hi[10], 1'b0, np, gp, ill, k, sys, dat};
	endfunction : exp_res

	// load descriptor, offset and control, then compare fault outputs, result word and upper word
	task automatic run(input logic [31:0] hi, lo, off, ctl);
		logic [31:0] e, m;
		logic        okl;
		e = exp_res(hi, lo, off, ctl, okl);
		m = e[0] ? 32'h0000_1dff : 32'h0000_11ff;
		apb(1'b1, `SDC_OFS_DESC_LO, lo);
		apb(1'b1, `SDC_OFS_DESC_HI, hi);
		apb(1'b1, `SDC_OFS_OFFSET, off);
		apb(1'b1, `SDC_OFS_CTRL, ctl);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({31'h0, gpf}, {31'h0, e[7]});
		chk({31'h0, npf}, {31'h0, e[8]});
		if (ctl[1:0] == 2'b10 && okl) exp_wsp = hi[22];
		chk({31'h0, wsp}, {31'h0, exp_wsp});
		apb(1'b0, `SDC_OFS_RESULT, 32'h0);
		chk(rd & m, e & m);
		apb(1'b0, `SDC_OFS_DESC_HI, 32'h0);
		chk(rd, hi | (okl ? 32'h0000_0100 : 32'h0));
	endtask : run

	// main sequence
	initial begin
		void'($urandom(32'h7fe1));
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		for (int a = 0; a < 7; a++) begin
			apb(1'b0, 12'(a * 4), 32'h0);
			chk(rd, (a == 3) ? 32'h0000_0003 : 32'h0);
		end
		apb(1'b1, 12'h01c, 32'h5);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 12'h01c, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		$display("test reset and map done");
		for (int t = 0; t < 16; t++)
			run(hw(0, 0, 0, 1, 0, t[3:0]), 32'h0, 32'h0, mk(0, 0, 0, 0, t[0]));
		for (int t = 0; t < 8; t++)
			run(hw(0, 0, 0, 1, 1, t[3:0]), 32'h10, 32'h4, mk(0, 1, 0, 0, 0));
		$display("test type codes done");
		run(hw(0, 0, 0, 1, 1, 2), 32'h100, 32'h100, mk(0, 0, 0, 0, 0));
		run(hw(0, 0, 0, 1, 1, 2), 32'h100, 32'hff, mk(0, 0, 0, 1, 0));
		run(hw(0, 0, 0, 1, 1, 2), 32'h100, 32'h100, mk(0, 0, 0, 1, 0));
		run(hw(0, 0, 0, 1, 1, 2), 32'h100, 32'hfe, mk(0, 0, 0, 3, 0));
		run(hw(0, 0, 0, 1, 1, 6), 32'h100, 32'h100, mk(0, 0, 0, 0, 0));
		run(hw(0, 0, 0, 1, 1, 6), 32'h100, 32'h101, mk(0, 1, 0, 0, 0));
		run(hw(0, 0, 0, 1, 1, 6), 32'h100, 32'hffff, mk(0, 0, 0, 0, 0));
		run(hw(0, 0, 0, 1, 1, 6), 32'h100, 32'hfffe, mk(0, 0, 0, 3, 0));
		run(hw(0, 1, 0, 1, 1, 6), 32'h100, 32'h10000, mk(0, 0, 0, 0, 0));
		run(hw(0, 1, 0, 1, 1, 6), 32'h100, 32'hfffffffc, mk(0, 0, 0, 3, 0));
		run(hw(1, 0, 0, 1, 1, 2), 32'h1, 32'h1fff, mk(0, 0, 0, 0, 0));
		run(hw(1, 0, 0, 1, 1, 2), 32'h1, 32'h2000, mk(0, 0, 0, 0, 0));
		run(hw(0, 0, 0, 1, 1, 2), 32'h100, 32'h0, mk(0, 0, 1, 0, 0));
		run(hw(0, 0, 0, 0, 1, 2), 32'h100, 32'h0, mk(0, 0, 0, 0, 0));
		$display("test bounds done");
		run(hw(0, 0, 0, 1, 1, 0), 32'h10, 32'h0, mk(1, 0, 0, 0, 0));
		run(hw(0, 0, 0, 1, 1, 1), 32'h10, 32'h0, mk(1, 0, 0, 0, 0));
		run(hw(0, 1, 0, 1, 1, 2), 32'h10, 32'h0, mk(2, 0, 0, 0, 0));
		run(hw(0, 0, 0, 1, 1, 6), 32'h10, 32'h0, mk(2, 0, 0, 0, 0));
		run(hw(0, 1, 0, 1, 1, 0), 32'h10, 32'h0, mk(2, 0, 0, 0, 0));
		run(hw(0, 1, 0, 1, 1, 4'ha), 32'h10, 32'h0, mk(2, 0, 0, 0, 0));
		run(hw(0, 1, 0, 1, 0, 2), 32'h10, 32'h0, mk(2, 0, 0, 0, 0));
		run(hw(0, 1, 0, 0, 1, 2), 32'h10, 32'h0, mk(2, 0, 0, 0, 0));
		run(hw(0, 0, 0, 1, 1, 2), 32'h10, 32'h0, mk(3, 0, 0, 0, 0));
		$display("test loads done");
		for (int i = 0; i < 40; i++) begin
			rd = $urandom;
			run(hw(rd[0], rd[1], {3'b0, rd[2]}, rd[3] | rd[4], rd[5] | rd[6], rd[11:8]),
				{16'h0, rd[31:16]}, {16'h0, rd[31:16]} + 32'($urandom_range(0, 8)) - 32'h4,
				mk(2'($urandom_range(0, 3)), rd[12], rd[13] & rd[14], rd[16:15], rd[17]));
		end
		$display("test random done");
		apb(1'b1, `SDC_OFS_INT_STAT, 32'hf);
		apb(1'b0, `SDC_OFS_INT_STAT, 32'h0);
		chk(rd, 32'h0);
		run(hw(0, 0, 0, 1, 1, 0), 32'h10, 32'h0, mk(0, 1, 0, 0, 0));
		apb(1'b0, `SDC_OFS_INT_STAT, 32'h0);
		chk(rd, 32'h3);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `SDC_OFS_INT_MASK, 32'h2);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, `SDC_OFS_INT_STAT, 32'h2);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, `SDC_OFS_INT_STAT, 32'h0);
		chk(rd, 32'h1);
		// a check launched just before the enable drops waits for it
		apb(1'b1, `SDC_OFS_CTRL, mk(0, 0, 0, 0, 0));
		ce <= 1'b0;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		chk({31'h0, gpf}, 32'h1);
		repeat (2) @(negedge clk);
		chk({31'h0, gpf}, 32'h0);
		$display("test interrupts done");
		wrap_up();
	end
endmodule : sdc_check_test

`default_nettype wire
